//--- shared/clk_cfg_pkg.sv
// Register map, field positions, reset values and codes for the clock source configuration block
package clk_cfg_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [9:0] pll_control_addr             = 10'h010;
  localparam logic [9:0] vco_calibration_control_addr = 10'h018;
  localparam logic [9:0] reference_input_select_addr  = 10'h01C;
  localparam logic [9:0] vco_divider_setting_addr     = 10'h1E0;
  localparam logic [9:0] input_routing_addr           = 10'h1E1;
  localparam logic [9:0] register_update_strobe_addr  = 10'h232;
  localparam logic [9:0] nvm_control_addr             = 10'h234;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int pll_power_lsb    = 0;
  localparam int polarity_bit     = 7;
  localparam int calibrate_bit    = 0;
  localparam int bypass_bit       = 0;
  localparam int source_bit       = 1;
  localparam int update_bit       = 0;
  localparam int nvm_store_bit    = 0;
  localparam int nvm_restore_bit  = 1;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] pll_power_normal = 2'h0;
  localparam logic [1:0] pll_power_down   = 2'h1;
  localparam logic [7:0] pll_control_rst  = 8'h01;
  localparam logic [7:0] zero_rst         = 8'h00;
  localparam logic [2:0] vco_div_code_max = 3'h4;

  typedef enum logic [1:0] {
    nvm_idle    = 2'b00,
    nvm_store   = 2'b01,
    nvm_restore = 2'b10
  } nvm_state_t;

endpackage

//--- hdl/clock_source_mode_config.sv
// Staged control registers and derived clock routing controls for the clock source
module clock_source_mode_config #(
  parameter int nvm_words = 5
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [9:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            pll_on,
  output logic            pll_async_down,
  output logic            vco_power,
  output logic            source_vco,
  output logic            divider_bypass,
  output logic      [2:0] vco_div_ratio,
  output logic            polarity_negative,
  output logic      [2:0] ref_enable,
  output logic            cal_start,
  output logic            nvm_busy
);

  // Word indices and the NVM walk are sized for exactly five stored registers
  if (nvm_words != 5) begin : g_words_check
    $error("nvm_words must be 5");
  end

  // ----------------------------------------------------------------
  // Staged and active register sets
  // ----------------------------------------------------------------
  logic [7:0] stage_q [nvm_words];
  logic [7:0] stage_d [nvm_words];
  logic [7:0] act_q   [nvm_words];
  logic [7:0] act_d   [nvm_words];
  logic [7:0] nvm_q   [nvm_words];
  logic [7:0] nvm_d   [nvm_words];
  logic [7:0] rdata_q, rdata_d;
  logic       cal_prev_q, cal_prev_d;
  logic       cal_start_q, cal_start_d;
  logic [2:0] nvm_idx_q, nvm_idx_d;
  clk_cfg_pkg::nvm_state_t nvm_st_q, nvm_st_d;
  logic       update;
  logic [2:0] widx;
  logic       whit;

  // Map an address onto a stored word index; update strobe is not stored
  always_comb begin
    whit = 1'b1;
    widx = 3'h0;
    case (addr)
      clk_cfg_pkg::pll_control_addr:             widx = 3'h0;
      clk_cfg_pkg::vco_calibration_control_addr: widx = 3'h1;
      clk_cfg_pkg::reference_input_select_addr:  widx = 3'h2;
      clk_cfg_pkg::vco_divider_setting_addr:     widx = 3'h3;
      clk_cfg_pkg::input_routing_addr:           widx = 3'h4;
      default:                                   whit = 1'b0;
    endcase
  end

  assign update = wr && (addr == clk_cfg_pkg::register_update_strobe_addr) && wdata[clk_cfg_pkg::update_bit];

  // Staging, commit and NVM sequencing; the NVM walks one word per cycle
  always_comb begin
    for (int i = 0; i < nvm_words; i++) begin
      stage_d[i] = stage_q[i];
      act_d[i]   = act_q[i];
      nvm_d[i]   = nvm_q[i];
    end
    nvm_st_d  = nvm_st_q;
    nvm_idx_d = nvm_idx_q;
    if (wr && whit && nvm_st_q == clk_cfg_pkg::nvm_idle) begin
      stage_d[widx] = wdata;
    end
    if (update && nvm_st_q == clk_cfg_pkg::nvm_idle) begin
      for (int i = 0; i < nvm_words; i++) begin
        act_d[i] = stage_q[i];
      end
      if (whit) act_d[widx] = wdata;
    end
    case (nvm_st_q)
      clk_cfg_pkg::nvm_idle: begin
        if (wr && addr == clk_cfg_pkg::nvm_control_addr) begin
          nvm_idx_d = 3'h0;
          if (wdata[clk_cfg_pkg::nvm_store_bit]) nvm_st_d = clk_cfg_pkg::nvm_store;
          else if (wdata[clk_cfg_pkg::nvm_restore_bit]) nvm_st_d = clk_cfg_pkg::nvm_restore;
        end
      end
      clk_cfg_pkg::nvm_store: begin
        nvm_d[nvm_idx_q] = act_q[nvm_idx_q];
        nvm_idx_d = nvm_idx_q + 3'h1;
        if (nvm_idx_q == 3'(nvm_words - 1)) nvm_st_d = clk_cfg_pkg::nvm_idle;
      end
      clk_cfg_pkg::nvm_restore: begin
        stage_d[nvm_idx_q] = nvm_q[nvm_idx_q];
        act_d[nvm_idx_q]   = nvm_q[nvm_idx_q];
        nvm_idx_d = nvm_idx_q + 3'h1;
        if (nvm_idx_q == 3'(nvm_words - 1)) nvm_st_d = clk_cfg_pkg::nvm_idle;
      end
      default: nvm_st_d = clk_cfg_pkg::nvm_idle;
    endcase
  end

  // Reset loads the distribution-only defaults; NVM contents survive reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < nvm_words; i++) begin
        stage_q[i] <= (i == 0) ? clk_cfg_pkg::pll_control_rst : clk_cfg_pkg::zero_rst;
        act_q[i]   <= (i == 0) ? clk_cfg_pkg::pll_control_rst : clk_cfg_pkg::zero_rst;
      end
      nvm_st_q  <= clk_cfg_pkg::nvm_restore;
      nvm_idx_q <= 3'h0;
    end else begin
      for (int i = 0; i < nvm_words; i++) begin
        stage_q[i] <= stage_d[i];
        act_q[i]   <= act_d[i];
      end
      nvm_st_q  <= nvm_st_d;
      nvm_idx_q <= nvm_idx_d;
    end
    for (int i = 0; i < nvm_words; i++) begin
      nvm_q[i] <= nvm_d[i];
    end
  end

  // ----------------------------------------------------------------
  // Calibration edge and read path
  // ----------------------------------------------------------------
  // Calibration fires only on a committed 0 to 1 edge, so the host must clear first
  always_comb begin
    cal_prev_d  = act_q[1][clk_cfg_pkg::calibrate_bit];
    cal_start_d = act_q[1][clk_cfg_pkg::calibrate_bit] && !cal_prev_q;
    rdata_d = 8'h00;
    if (rd) begin
      if (whit) rdata_d = stage_q[widx];
      else if (addr == clk_cfg_pkg::nvm_control_addr) rdata_d = {7'h00, nvm_st_q != clk_cfg_pkg::nvm_idle};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cal_prev_q  <= 1'b0;
      cal_start_q <= 1'b0;
      rdata_q     <= 8'h00;
    end else begin
      cal_prev_q  <= cal_prev_d;
      cal_start_q <= cal_start_d;
      rdata_q     <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Derived controls from the active set
  // ----------------------------------------------------------------
  // Codes 10 and 11 assert neither pll_on nor pll_async_down; only 00 runs the loop and only 01 powers down
  assign pll_on         = act_q[0][1:0] == clk_cfg_pkg::pll_power_normal;
  assign pll_async_down = act_q[0][1:0] == clk_cfg_pkg::pll_power_down;
  assign source_vco     = act_q[4][clk_cfg_pkg::source_bit];
  assign divider_bypass = act_q[4][clk_cfg_pkg::bypass_bit];
  // Codes above the fifth step clamp to divide-by-six
  assign vco_div_ratio  = (act_q[3][2:0] > clk_cfg_pkg::vco_div_code_max) ? 3'h6 : 3'(act_q[3][2:0] + 3'h2);
  assign polarity_negative = act_q[0][clk_cfg_pkg::polarity_bit];
  assign ref_enable     = act_q[2][2:0];
  // External source with PLL on: VCO off, external oscillator to prescaler
  assign vco_power      = pll_on && source_vco;
  assign cal_start      = cal_start_q;
  assign nvm_busy       = nvm_st_q != clk_cfg_pkg::nvm_idle;
  assign rdata          = rdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_pll_on;
    @(posedge mclk) disable iff (rst) pll_on |-> (act_q[0][1:0] == 2'h0) && !pll_async_down;
  endproperty
  a_pll_on: assert property (p_pll_on) else $error("pll on with wrong code");

  property p_pll_down;
    @(posedge mclk) disable iff (rst) (act_q[0][1:0] == 2'h1) |-> !pll_on && pll_async_down && !vco_power;
  endproperty
  a_pll_down: assert property (p_pll_down) else $error("pll down not honoured");

  property p_source;
    @(posedge mclk) disable iff (rst) update && !nvm_busy && !whit |=> source_vco == $past(stage_q[4][1]);
  endproperty
  a_source: assert property (p_source) else $error("source not committed");

  property p_bypass;
    @(posedge mclk) disable iff (rst) update && !nvm_busy && !whit |=> divider_bypass == $past(stage_q[4][0]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not committed");

  property p_ratio;
    @(posedge mclk) disable iff (rst) (act_q[3][2:0] == 3'h0) |-> vco_div_ratio == 3'h2;
  endproperty
  a_ratio: assert property (p_ratio) else $error("code 0 not divide by two");

  property p_polarity;
    @(posedge mclk) disable iff (rst) $changed(polarity_negative) |-> $past(update) || $past(nvm_busy);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity changed without update");

  property p_reset;
    @(posedge mclk) $fell(rst) |-> pll_async_down && !source_vco && !divider_bypass && vco_div_ratio == 3'h2;
  endproperty
  a_reset: assert property (p_reset) else $error("reset defaults wrong");

  property p_ext_vco_off;
    @(posedge mclk) disable iff (rst) pll_on && !source_vco |-> !vco_power;
  endproperty
  a_ext_vco_off: assert property (p_ext_vco_off) else $error("vco powered with external source");

  property p_cal;
    @(posedge mclk) disable iff (rst) cal_start |-> $past(act_q[1][0]) && !$past(cal_prev_q) ##1 !cal_start;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration start wrong");

  property p_stage;
    @(posedge mclk) disable iff (rst) wr && whit && !update && !nvm_busy |=> $stable(act_q[0]) && $stable(act_q[1])
      && $stable(act_q[2]) && $stable(act_q[3]) && $stable(act_q[4]);
  endproperty
  a_stage: assert property (p_stage) else $error("write leaked to active set");

  property p_nvm;
    @(posedge mclk) disable iff (rst) $rose(nvm_busy) |-> ##[1:6] !nvm_busy;
  endproperty
  a_nvm: assert property (p_nvm) else $error("nvm sequence too long");

  // Power codes are exclusive, whatever the unused codes do
  property p_power_excl;
    @(posedge mclk) disable iff (rst) pll_async_down |-> !pll_on;
  endproperty
  a_power_excl: assert property (p_power_excl) else $error("pll on while powered down");

  property p_vco_int;
    @(posedge mclk) disable iff (rst) pll_on && source_vco |-> vco_power;
  endproperty
  a_vco_int: assert property (p_vco_int) else $error("internal vco not powered");

  property p_vco_off_down;
    @(posedge mclk) disable iff (rst) !pll_on |-> !vco_power;
  endproperty
  a_vco_off_down: assert property (p_vco_off_down) else $error("vco powered with loop off");

  property p_ratio_top;
    @(posedge mclk) disable iff (rst) (act_q[3][2:0] == 3'h4) |-> vco_div_ratio == 3'h6;
  endproperty
  a_ratio_top: assert property (p_ratio_top) else $error("top divider code wrong");

  // Out-of-range codes must not wrap to a fast ratio
  property p_ratio_clamp;
    @(posedge mclk) disable iff (rst) (act_q[3][2:0] > clk_cfg_pkg::vco_div_code_max) |-> vco_div_ratio == 3'h6;
  endproperty
  a_ratio_clamp: assert property (p_ratio_clamp) else $error("divider code not clamped");

  property p_power_commit;
    @(posedge mclk) disable iff (rst) update && !nvm_busy |=> act_q[0] == $past(stage_q[0]);
  endproperty
  a_power_commit: assert property (p_power_commit) else $error("pll control not committed");

  property p_ref_commit;
    @(posedge mclk) disable iff (rst) update && !nvm_busy |=> ref_enable == $past(stage_q[2][2:0]);
  endproperty
  a_ref_commit: assert property (p_ref_commit) else $error("reference enables not committed");

  property p_div_commit;
    @(posedge mclk) disable iff (rst) update && !nvm_busy |=> act_q[3] == $past(stage_q[3]);
  endproperty
  a_div_commit: assert property (p_div_commit) else $error("divider not committed");

  property p_read_stage;
    @(posedge mclk) disable iff (rst) rd && whit |=> rdata == $past(stage_q[widx]);
  endproperty
  a_read_stage: assert property (p_read_stage) else $error("read did not return staged value");

  property p_read_idle;
    @(posedge mclk) disable iff (rst) !rd |=> rdata == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data held too long");

  property p_cal_hold;
    @(posedge mclk) disable iff (rst) cal_prev_q |=> !cal_start;
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("calibration without prior clear");

  property p_store_copy;
    @(posedge mclk) disable iff (rst) nvm_st_q == clk_cfg_pkg::nvm_store |=> nvm_q[$past(nvm_idx_q)] == $past(act_q[nvm_idx_q]);
  endproperty
  a_store_copy: assert property (p_store_copy) else $error("nvm store copied wrong word");

endmodule

//--- dv/clk_cfg_host.sv
// Host model that programs the configuration registers over the strobe bus
module clk_cfg_host (
  input  wire logic       mclk,
  output logic      [9:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // Bus cycles
  // ------------------------------------------------
  // Idle bus at time zero
  initial begin
    addr  = 10'h000;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  // Edge of gap first, so a strobe is never lowered and raised in one step
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Commit everything staged so far
  task automatic update();
    wr_reg(clk_cfg_pkg::register_update_strobe_addr, 8'h01);
  endtask
  // Calibrate bit first, then the commit
  task automatic calibrate();
    wr_reg(clk_cfg_pkg::vco_calibration_control_addr, 8'h01);
    update();
  endtask
  // A later calibration needs the bit cleared and committed first
  task automatic recalibrate();
    wr_reg(clk_cfg_pkg::vco_calibration_control_addr, 8'h00);
    update();
    calibrate();
  endtask
endmodule

//--- dv/clock_source_mode_config_tb.sv
// Self-checking bench for the clock source configuration block
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s: expected %0h, seen %0h", n, e, g); end end
module clock_source_mode_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, rst, wr, rd, pll_on, pll_async_down, vco_power, source_vco;
  logic       divider_bypass, polarity_negative, cal_start, nvm_busy;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic [2:0] vco_div_ratio, ref_enable;
  int         fail_count, compares;
  int         cal_count = 0;
  clock_source_mode_config dut (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .pll_on, .pll_async_down,
    .vco_power, .source_vco, .divider_bypass, .vco_div_ratio, .polarity_negative, .ref_enable, .cal_start, .nvm_busy);
  clk_cfg_host host (.mclk, .addr, .wdata, .wr, .rd, .rdata);
  // ------------------------------------------------
  // Clock, pulse counter and helpers
  // ------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Counting pulses avoids pinning the exact launch edge
  always @(posedge mclk) if (cal_start === 1'b1) cal_count++;
  task automatic wrap_up();
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded wait for a store or restore walk to end
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge mclk);
    #1;
    while (nvm_busy !== 1'b0) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 50) begin
        fail_count++;
        wrap_up();
      end
    end
  endtask
  // Defaults are checked while reset is still held
  task automatic do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    `CHK("pll_async_down", 1'b1, pll_async_down)
    `CHK("vco_div_ratio", 3'h2, vco_div_ratio)
    `CHK("source_vco", 1'b0, source_vco)
    `CHK("divider_bypass", 1'b0, divider_bypass)
    @(posedge mclk);
    rst <= 1'b0;
    wait_idle();
  endtask
  // Power/polarity, divider and routing, then commit
  task automatic cfg(input logic [7:0] p, input logic [7:0] dv, input logic [7:0] rt);
    host.wr_reg(clk_cfg_pkg::pll_control_addr, p);
    host.wr_reg(clk_cfg_pkg::vco_divider_setting_addr, dv);
    host.wr_reg(clk_cfg_pkg::input_routing_addr, rt);
    host.update();
    @(posedge mclk);
    #1;
  endtask
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    rst = 1'b1;
    fail_count = 0;
    compares = 0;
    do_reset();
    // Restored content is undefined until a store, so load every register
    host.wr_reg(clk_cfg_pkg::reference_input_select_addr, 8'h05);
    host.wr_reg(clk_cfg_pkg::vco_calibration_control_addr, 8'h00);
    cfg(8'h01, 8'h00, 8'h00);
    `CHK("ref_enable", 3'h5, ref_enable)
    host.wr_reg(clk_cfg_pkg::pll_control_addr, 8'h80);
    #1;
    `CHK("staged pll_on", 1'b0, pll_on)
    host.rd_reg(clk_cfg_pkg::pll_control_addr, rv);
    `CHK("staged read", 8'h80, rv)
    host.rd_reg(10'h3FF, rv);
    `CHK("unmapped read", 8'h00, rv)
    host.update();
    @(posedge mclk);
    #1;
    `CHK("pll_on", 1'b1, pll_on)
    `CHK("polarity", 1'b1, polarity_negative)
    `CHK("vco_power ext", 1'b0, vco_power)
    // Bypass only for a slow source
    cfg(8'h00, 8'h00, 8'h03);
    `CHK("source_vco", 1'b1, source_vco)
    `CHK("bypass", 1'b1, divider_bypass)
    `CHK("vco_power int", 1'b1, vco_power)
    `CHK("polarity pos", 1'b0, polarity_negative)
    cfg(8'h01, 8'h00, 8'h02);
    `CHK("pll_async_down", 1'b1, pll_async_down)
    `CHK("pll_on off", 1'b0, pll_on)
    `CHK("bypass off", 1'b0, divider_bypass)
    // Channel divider input kept low by the divider ratio
    for (int c = 0; c < 5; c++) begin
      cfg(8'h01, 8'(c), 8'h00);
      `CHK("ratio", 3'(c + 2), vco_div_ratio)
    end
    cfg(8'h01, 8'h07, 8'h00);
    `CHK("ratio clamp", 3'h6, vco_div_ratio)
    host.calibrate();
    repeat (4) @(posedge mclk);
    `CHK("cal pulses", 1, cal_count)
    host.calibrate();
    repeat (4) @(posedge mclk);
    `CHK("cal no clear", 1, cal_count)
    host.recalibrate();
    repeat (4) @(posedge mclk);
    `CHK("cal again", 2, cal_count)
    // Store, reset, and expect the stored setup back
    cfg(8'h80, 8'h03, 8'h03);
    host.wr_reg(clk_cfg_pkg::nvm_control_addr, 8'h01);
    wait_idle();
    do_reset();
    `CHK("restored polarity", 1'b1, polarity_negative)
    `CHK("restored source", 1'b1, source_vco)
    `CHK("restored ratio", 3'h5, vco_div_ratio)
    wrap_up();
  end
endmodule
